// File: logic/adc_demux_pkg.sv
// Constants, types and register map for the converter output formatter
// Overview of operation
// - Each sample is captured on the sampling clock rising edge, then formatted.
// - Outputs are offset binary, true and complement pairs, bit 7 most significant.
// - split_enable high turns splitting on; low forces full_rate_mode.
// - With splitting on, rate_select low gives split_mode, high decimate_mode.
// - full_rate_mode puts every sample on the first port, one word per clock.
// - full_rate_mode second port repeats the first port one clock later.
// - Both second-port power bits low: second port true and complement go high.
// - split_mode halves word rate, two consecutive samples per strobe rise.
// - split_mode second port holds the older sample, first port the newer.
// - decimate_mode drops every other sample, each port runs at quarter rate.
// - Data changes on the word_strobe rising edge, on either edge in full_rate_mode; receiver latches on the rise.
// - In split modes out_of_range_flag is set if either port is overranged.
// - In full_rate_mode out_of_range_flag follows the first port only.
// - sync_reset_in realigns word phase; sync_reset_out forwards it.
package adc_demux_pkg;

  localparam int DATA_W = 8;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] STATUS_OFS     = 8'h04;
  localparam logic [7:0] OVER_COUNT_OFS = 8'h08;

  // Control register fields
  localparam int CTRL_SPLIT_BIT = 0;
  localparam int CTRL_RATE_BIT  = 1;
  localparam int CTRL_PWR_A_BIT = 2;
  localparam int CTRL_PWR_B_BIT = 3;
  localparam int CTRL_W         = 4;
  localparam logic [3:0] CTRL_RESET = 4'hC;

  // Status register fields
  localparam int STATUS_MODE_LSB = 0;
  localparam int STATUS_PWR_BIT  = 2;

  localparam int OVER_COUNT_W = 16;

  // Word phase positions
  localparam logic [1:0] PHASE_FIRST     = 2'h0;
  localparam logic [1:0] PHASE_SECOND    = 2'h1;
  localparam logic [1:0] PHASE_DEC_KEEP  = 2'h2;
  localparam logic [1:0] PHASE_DEC_LAST  = 2'h3;

  localparam logic [1:0] LINK_RST_INIT = 2'h3;

  typedef enum logic [1:0] {
    full_rate_mode,
    split_mode,
    decimate_mode
  } mode_t;

  typedef struct packed {
    logic [DATA_W-1:0] pos;
    logic [DATA_W-1:0] neg;
  } diff8_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } diff1_t;

endpackage

// File: logic/adc_output_demux.sv
// Output formatter: mode select, pairing, strobe, overrange, Wishbone regs
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module adc_output_demux
  import adc_demux_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                sample_clk,
  input  wire logic [DATA_W-1:0]   sample_data,
  input  wire logic                sample_over,
  input  wire logic                sync_reset_in,
  output diff8_t                   first_port_bits,
  output diff8_t                   second_port_bits,
  output diff1_t                   word_strobe,
  output diff1_t                   out_of_range_flag,
  output diff1_t                   sync_reset_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the register side (mclk)

  typedef struct packed {
    logic                    ack;
    logic [31:0]             dat;
    logic [CTRL_W-1:0]       ctrl;
    logic [1:0]              mode_s1;
    logic [1:0]              mode_s2;
    logic                    pwr_s1;
    logic                    pwr_s2;
    logic [2:0]              tgl_s;
    logic [OVER_COUNT_W-1:0] over_count;
  } bus_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // State of the sampling side (sample_clk)

  typedef struct packed {
    logic [1:0]        rst_sync;
    logic [CTRL_W-1:0] ctrl_s1;
    logic [CTRL_W-1:0] ctrl_s2;
    logic [CTRL_W-1:0] ctrl_s3;
    logic              rsin_s1;
    logic              rsin_s2;
    logic [DATA_W-1:0] cap;
    logic              cap_over;
    mode_t             mode;
    logic [1:0]        phase;
    logic [DATA_W-1:0] held;
    logic              held_over;
    logic              powered;
    logic              over_tgl;
    diff8_t            first_q;
    diff8_t            second_q;
    diff1_t            strobe_q;
    diff1_t            oor_q;
    diff1_t            rso_q;
  } link_state_t;

  bus_state_t  bus;
  bus_state_t  next_bus;
  link_state_t link;
  link_state_t next_link;

  ////////////////////////////////////////////////////////////////////////////
  // Register side

  logic bus_req;
  logic bus_wr;
  logic over_event;

  always_comb begin
    next_bus = bus;
    bus_req  = wb_cyc_i & wb_stb_i & ~bus.ack;
    bus_wr   = wb_cyc_i & wb_stb_i & wb_we_i & bus.ack;

    // One wait state, then ack for a single cycle
    next_bus.ack = bus_req;

    if (bus_req) begin
      case (wb_adr_i)
        CTRL_OFS: begin
          next_bus.dat = {{(32-CTRL_W){1'b0}}, bus.ctrl};
        end
        STATUS_OFS: begin
          next_bus.dat = {29'h0000000, bus.pwr_s2, bus.mode_s2};
        end
        OVER_COUNT_OFS: begin
          next_bus.dat = {{(32-OVER_COUNT_W){1'b0}}, bus.over_count};
        end
        default: begin
          next_bus.dat = 32'h00000000;
        end
      endcase
    end

    // Write lands at the edge where the master sees ack
    if (bus_wr && wb_adr_i == CTRL_OFS && wb_sel_i[0]) begin
      next_bus.ctrl = wb_dat_i[CTRL_W-1:0];
    end

    // Mode and power only change when software rewrites control
    next_bus.mode_s1 = link.mode;
    next_bus.mode_s2 = bus.mode_s1;
    next_bus.pwr_s1  = link.powered;
    next_bus.pwr_s2  = bus.pwr_s1;

    // Toggle crossing; only the third stage pair feeds the detector
    next_bus.tgl_s = {bus.tgl_s[1:0], link.over_tgl};
    over_event     = bus.tgl_s[2] ^ bus.tgl_s[1];

    // Any write to the count register clears it; a coincident event still counts
    if (bus_wr && wb_adr_i == OVER_COUNT_OFS) begin
      next_bus.over_count = over_event ? 16'h0001 : 16'h0000;
    end else if (over_event && bus.over_count != 16'hFFFF) begin
      next_bus.over_count = bus.over_count + 16'h0001;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus      <= '0;
      bus.ctrl <= CTRL_RESET;
    end else begin
      bus <= next_bus;
    end
  end

  assign wb_ack_o = bus.ack;
  assign wb_dat_o = bus.dat;

  ////////////////////////////////////////////////////////////////////////////
  // Sampling side

  mode_t             new_mode;
  logic              realign;
  logic              word_out;
  logic              word_over;
  logic [DATA_W-1:0] first_val;
  logic [DATA_W-1:0] second_val;

  always_comb begin
    next_link = link;

    next_link.rsin_s1 = sync_reset_in;
    next_link.rsin_s2 = link.rsin_s1;
    next_link.ctrl_s1 = bus.ctrl;
    next_link.ctrl_s2 = link.ctrl_s1;
    next_link.ctrl_s3 = link.ctrl_s2;

    // Capture register stands for the converter's aperture stage
    next_link.cap      = sample_data;
    next_link.cap_over = sample_over;

    // Bits cross one by one; act only on a value seen twice in a row
    new_mode = link.mode;
    if (link.ctrl_s2 == link.ctrl_s3) begin
      if (!link.ctrl_s3[CTRL_SPLIT_BIT]) begin
        new_mode = full_rate_mode;
      end else if (link.ctrl_s3[CTRL_RATE_BIT]) begin
        new_mode = decimate_mode;
      end else begin
        new_mode = split_mode;
      end
      // Second port driven only if either power bit is set
      next_link.powered = link.ctrl_s3[CTRL_PWR_A_BIT] |
                          link.ctrl_s3[CTRL_PWR_B_BIT];
    end
    next_link.mode = new_mode;

    realign    = (new_mode != link.mode) || link.rsin_s2;
    word_out   = 1'b0;
    first_val  = link.first_q.pos;
    second_val = link.second_q.pos;
    word_over  = link.oor_q.pos;

    if (realign) begin
      next_link.phase        = PHASE_FIRST;
      next_link.strobe_q.pos = 1'b0;
    end else begin
      case (link.mode)
        full_rate_mode: begin
          word_out   = 1'b1;
          first_val  = link.cap;
          second_val = link.first_q.pos;
          word_over  = link.cap_over;
          // Both edges mark words: a flop cannot run at clock rate
          next_link.strobe_q.pos = ~link.strobe_q.pos;
        end
        split_mode: begin
          if (link.phase == PHASE_FIRST) begin
            next_link.held      = link.cap;
            next_link.held_over = link.cap_over;
            next_link.phase     = PHASE_SECOND;
            next_link.strobe_q.pos = 1'b0;
          end else begin
            word_out   = 1'b1;
            first_val  = link.cap;
            second_val = link.held;
            word_over  = link.cap_over | link.held_over;
            next_link.phase        = PHASE_FIRST;
            next_link.strobe_q.pos = 1'b1;
          end
        end
        decimate_mode: begin
          next_link.phase = link.phase + 2'h1;
          if (link.phase == PHASE_FIRST) begin
            next_link.held      = link.cap;
            next_link.held_over = link.cap_over;
            next_link.strobe_q.pos = 1'b0;
          end else if (link.phase == PHASE_DEC_KEEP) begin
            // Phases one and three are the dropped samples
            word_out   = 1'b1;
            first_val  = link.cap;
            second_val = link.held;
            word_over  = link.cap_over | link.held_over;
            next_link.strobe_q.pos = 1'b1;
          end else if (link.phase == PHASE_DEC_LAST) begin
            next_link.strobe_q.pos = 1'b1;
          end else begin
            next_link.strobe_q.pos = 1'b0;
          end
        end
        default: begin
          next_link.phase = PHASE_FIRST;
        end
      endcase
    end

    // Data and flag move together with the strobe rise, or with either strobe edge in full_rate_mode
    if (word_out) begin
      next_link.first_q.pos  = first_val;
      next_link.second_q.pos = second_val;
      next_link.oor_q.pos    = word_over;
      if (word_over) begin
        next_link.over_tgl = ~link.over_tgl;
      end
    end

    next_link.first_q.neg  = ~next_link.first_q.pos;
    next_link.second_q.neg = ~next_link.second_q.pos;
    if (!next_link.powered) begin
      next_link.second_q.pos = {DATA_W{1'b1}};
      next_link.second_q.neg = {DATA_W{1'b1}};
    end
    next_link.strobe_q.neg = ~next_link.strobe_q.pos;
    next_link.oor_q.neg    = ~next_link.oor_q.pos;

    next_link.rso_q.pos = link.rsin_s2;
    next_link.rso_q.neg = ~link.rsin_s2;

    next_link.rst_sync = {link.rst_sync[0], 1'b0};

    // Hold all but the sync_reset_in synchronizer and the first two control stages while the local reset release settles
    if (link.rst_sync[1]) begin
      next_link          = link;
      next_link.rst_sync = {link.rst_sync[0], 1'b0};
      next_link.rsin_s1  = sync_reset_in;
      next_link.rsin_s2  = link.rsin_s1;
      next_link.ctrl_s1  = bus.ctrl;
      next_link.ctrl_s2  = link.ctrl_s1;
    end
  end

  always_ff @(posedge sample_clk or posedge rst) begin
    if (rst) begin
      link              <= '0;
      link.rst_sync     <= LINK_RST_INIT;
      link.ctrl_s1      <= CTRL_RESET;
      link.ctrl_s2      <= CTRL_RESET;
      link.ctrl_s3      <= CTRL_RESET;
      link.powered      <= 1'b1;
      link.first_q.neg  <= {DATA_W{1'b1}};
      link.second_q.neg <= {DATA_W{1'b1}};
      link.strobe_q.neg <= 1'b1;
      link.oor_q.neg    <= 1'b1;
      link.rso_q.neg    <= 1'b1;
    end else begin
      link <= next_link;
    end
  end

  assign first_port_bits   = link.first_q;
  assign second_port_bits  = link.second_q;
  assign word_strobe       = link.strobe_q;
  assign out_of_range_flag = link.oor_q;
  assign sync_reset_out    = link.rso_q;

endmodule

// File: verif/adc_output_demux_asserts.sv
// Port assertions for the converter output formatter, link side
`timescale 1ns/1ps
module adc_output_demux_asserts
  import adc_demux_pkg::*;
(
  input wire logic sample_clk,
  input wire logic rst,
  input wire logic sync_reset_in,
  input diff8_t    first_port_bits,
  input diff8_t    second_port_bits,
  input diff1_t    word_strobe,
  input diff1_t    out_of_range_flag,
  input diff1_t    sync_reset_out
);
  default clocking cb @(posedge sample_clk); endclocking
  default disable iff (rst);

  AST_FIRST_COMPL:
    assert property (first_port_bits.neg == ~first_port_bits.pos)
    else $error("first port pair not complementary");
  AST_SECOND_PAIR:
    assert property ((second_port_bits.neg == ~second_port_bits.pos) ||
      (second_port_bits.pos == 8'hFF && second_port_bits.neg == 8'hFF))
    else $error("second port pair neither driven nor parked high");
  AST_FLAG_COMPL:
    assert property (out_of_range_flag.neg == ~out_of_range_flag.pos)
    else $error("flag pair not complementary");
  AST_DATA_ON_STROBE:
    assert property ($changed(first_port_bits.pos) |->
      $changed(word_strobe.pos))
    else $error("first port moved without a strobe edge");
  AST_FLAG_WITH_WORD:
    assert property ($changed(out_of_range_flag.pos) |->
      $changed(word_strobe.pos))
    else $error("flag moved without a strobe edge");
  AST_STROBE_MAX_HIGH:
    assert property (word_strobe.pos [*2] |=> !word_strobe.pos)
    else $error("strobe high for more than two cycles");
  AST_SYNC_OUT:
    assert property ($rose(sync_reset_in) |-> ##[1:4] sync_reset_out.pos)
    else $error("sync reset not forwarded in time");
  AST_SYNC_HOLDS_STROBE:
    assert property (sync_reset_in [*6] |-> !word_strobe.pos)
    else $error("strobe running during sync reset");
endmodule

bind adc_output_demux adc_output_demux_asserts u_chk (
  .sample_clk(sample_clk), .rst(rst), .sync_reset_in(sync_reset_in),
  .first_port_bits(first_port_bits), .second_port_bits(second_port_bits),
  .word_strobe(word_strobe), .out_of_range_flag(out_of_range_flag),
  .sync_reset_out(sync_reset_out));

// File: verif/capture_model.sv
// Downstream capture logic latching both ports on the word strobe
`timescale 1ns/1ps
module capture_model
  import adc_demux_pkg::*;
(
  input diff1_t      word_strobe,
  input diff8_t      first_port_bits,
  input diff8_t      second_port_bits,
  input diff1_t      out_of_range_flag,
  output logic [7:0] cap_first,
  output logic [7:0] cap_second,
  output logic       cap_flag,
  output int         words
);
  initial words = 0;
  // Latch just after the rise: the same edge launches the data
  always @(posedge word_strobe.pos) begin
    #2;
    cap_first = first_port_bits.pos;
    cap_second = second_port_bits.pos;
    cap_flag = out_of_range_flag.pos;
    words = words + 1;
  end
endmodule

// File: verif/tb_adc_output_demux.sv
// Self-checking bench for the converter output formatter
`timescale 1ns/1ps
module tb_adc_output_demux
  import adc_demux_pkg::*;
;
  logic mclk, rst, cyc, stb, we, ack, sclk, sync_in, s_over, cfl, over_en;
  logic [7:0] adr, s_data, cf, cs;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  diff8_t fp, sp;
  diff1_t ws, ofl, so;
  int words, failures, checks_done, ticks;

  adc_output_demux dut_u (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sample_clk(sclk),
    .sample_data(s_data), .sample_over(s_over), .sync_reset_in(sync_in),
    .first_port_bits(fp), .second_port_bits(sp), .word_strobe(ws),
    .out_of_range_flag(ofl), .sync_reset_out(so));
  capture_model capture_u (.word_strobe(ws), .first_port_bits(fp),
    .second_port_bits(sp), .out_of_range_flag(ofl), .cap_first(cf),
    .cap_second(cs), .cap_flag(cfl), .words(words));

  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  // Odd offset keeps the link clock out of phase with mclk
  initial begin
    sclk = 0;
    #7;
    forever #32 sclk = ~sclk;
  end
  always @(posedge sclk) begin
    s_data <= s_data + 8'h01;
    s_over <= over_en & (s_data[1:0] == 2'h0);
  end
  always @(posedge mclk) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      failures = failures + 1;
      print_verdict;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic ov(input logic [7:0] x);
    return x[1:0] == 2'h1;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic set_mode(input logic [3:0] c);
    wb(1'b1, 8'h00, {28'h0, c});
    repeat (12) @(posedge sclk);
  endtask
  task automatic t_regs;
    wb(1'b0, 8'h00, 32'h0); chk(q, 32'hC);
    wb(1'b1, 8'h04, 32'h3);
    wb(1'b0, 8'h04, 32'h0); chk(q, 32'h4);
    wb(1'b0, 8'h0C, 32'h0); chk(q, 32'h0);
  endtask
  task automatic t_full;
    logic [7:0] p;
    set_mode(4'hE);
    wb(1'b0, 8'h04, 32'h0); chk(q, 32'h4);
    repeat (4) begin
      @(negedge sclk);
      p = fp.pos;
      chk(sp.pos, 8'(p - 8'h01));
      chk(ofl.pos, ov(p));
      @(negedge sclk);
      chk(fp.pos, 8'(p + 8'h01));
    end
  endtask
  task automatic t_split(input logic [3:0] c, input logic [7:0] gap,
                         input int rate, input logic [31:0] st);
    int n;
    set_mode(c);
    wb(1'b0, 8'h04, 32'h0); chk(q, st);
    // Count from just after a strobe rise so the window is phase-free
    @(posedge ws.pos);
    @(negedge sclk);
    n = words;
    repeat (32) @(negedge sclk);
    chk(32'(words - n), rate);
    chk(cf, 8'(cs + gap));
    chk(cfl, ov(cf) | ov(cs));
  endtask
  task automatic t_power;
    set_mode(4'h0);
    chk({sp.pos, sp.neg}, 16'hFFFF);
    wb(1'b0, 8'h04, 32'h0); chk(q, 32'h0);
  endtask
  task automatic t_count;
    over_en <= 1'b0;
    repeat (16) @(posedge sclk);
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b0, 8'h08, 32'h0); chk(q, 32'h0);
    @(posedge sclk);
    // Eight consecutive samples hold exactly two overranged ones
    over_en <= 1'b1;
    repeat (8) @(posedge sclk);
    over_en <= 1'b0;
    repeat (16) @(posedge sclk);
    wb(1'b0, 8'h08, 32'h0); chk(q, 32'h2);
  endtask
  task automatic t_sync;
    int n;
    set_mode(4'hD);
    sync_in <= 1'b1;
    repeat (8) @(negedge sclk);
    chk(so.pos, 1'b1);
    chk(ws.pos, 1'b0);
    @(posedge sclk);
    sync_in <= 1'b0;
    // Two sync stages, one pairing slot, then the first word
    repeat (4) @(negedge sclk);
    chk(ws.pos, 1'b0);
    @(negedge sclk);
    chk(ws.pos, 1'b1);
    chk(so.pos, 1'b0);
    n = words;
    repeat (8) @(negedge sclk);
    chk(32'(words - n), 32'h4);
  endtask
  task automatic print_verdict;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    {cyc, stb, we, sync_in, s_over} = '0;
    {adr, s_data, wdat} = '0;
    sel = 4'h1;
    over_en = 1'b1;
    {failures, checks_done, ticks} = '0;
    rst = 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_regs;
    t_full;
    t_split(4'hD, 8'h01, 16, 32'h5);
    t_split(4'hF, 8'h02, 8, 32'h6);
    t_power;
    t_count;
    t_sync;
    print_verdict;
  end
endmodule
